// ### rpo_pkg.sv
package rpo_pkg;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 25;
   localparam int OUT_HALF_NS = 50;
   localparam int OUT_HALF_CYC = (OUT_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int FIFO_DEPTH = 32;

   // ----------------------------------------------------------------
   // Register map (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [3:0] ADR_CTRL = 4'h0;
   localparam logic [3:0] ADR_STATUS = 4'h4;
   localparam int CTRL_LAUNCH_EN = 0;
   localparam int CTRL_CLR_OVF = 1;
   localparam logic [1:0] CTRL_RST = 2'h1;
   localparam int ST_COUNT_LSB = 0;
   localparam int ST_OVF = 8;
   localparam int ST_CHIP_AWAKE = 9;
   localparam int ST_DRV_AWAKE = 10;
   localparam int ST_TWO_PIX = 11;
   localparam int ST_HOLD = 12;

   // ----------------------------------------------------------------
   // Carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [1:0] ctl;
      logic vsync;
      logic hsync;
      logic de;
      logic [7:0] red;
      logic [7:0] green;
      logic [7:0] blue;
   } rpo_pix_t;

   localparam rpo_pix_t PIX_ZERO = '0;

   typedef struct packed {
      logic chipSleepN;
      logic drvSleepN;
      logic widthSel;
      logic edgeSel;
      logic syncDet;
      logic pixClk;
      rpo_pix_t pix;
   } rpo_pins_t;

   // Sleep pins rest at the normal-operation level, like their pull-ups.
   localparam rpo_pins_t PINS_RST = '{chipSleepN: 1'b1, drvSleepN: 1'b1, widthSel: 1'b0,
      edgeSel: 1'b0, syncDet: 1'b0, pixClk: 1'b0, pix: '0};

   typedef enum logic [2:0] {
      OS_IDLE = 3'b001,
      OS_LAUNCH = 3'b010,
      OS_CAPTURE = 3'b100
   } rpo_ostate_t;

endpackage : rpo_pkg

// ### rpo_pixel_out.sv
// The register addresses and the Wishbone interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module rpo_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32
) (
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic flush,
   // Fill side
   input wire logic inVld,
   output logic inRdy,
   input wire logic [WIDTH-1:0] inData,
   // Drain side
   output logic outVld,
   input wire logic outRdy,
   output logic [WIDTH-1:0] outData,
   output logic [$clog2(DEPTH):0] count
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d;
   logic push, pop;

   assign count = wrPtr_q - rdPtr_q;
   assign inRdy = (count != (AW + 1)'(DEPTH)) && !flush;
   assign outVld = (count != '0) && !flush;
   assign outData = mem[rdPtr_q[AW-1:0]];
   assign push = inVld && inRdy;
   assign pop = outVld && outRdy;

   always_comb begin
      wrPtr_d = wrPtr_q;
      rdPtr_d = rdPtr_q;
      if (flush) begin
         wrPtr_d = '0;
         rdPtr_d = '0;
      end else begin
         if (push) begin
            wrPtr_d = wrPtr_q + 1'b1;
         end
         if (pop) begin
            rdPtr_d = rdPtr_q + 1'b1;
         end
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         wrPtr_q <= '0;
         rdPtr_q <= '0;
      end else begin
         wrPtr_q <= wrPtr_d;
         rdPtr_q <= rdPtr_d;
      end
   end

   // Storage has no reset so it maps onto plain RAM.
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wrPtr_q[AW-1:0]] <= inData;
      end
   end
endmodule : rpo_fifo

module rpo_pixel_out
   import rpo_pkg::*;
#(
   parameter int HALF_CYC = OUT_HALF_CYC,
   parameter int DEPTH = FIFO_DEPTH
) (
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Decoded pixel stream on the recovered pixel clock
   input wire logic pixClkIn,
   input wire rpo_pix_t pixIn,
   input wire logic syncDetIn,
   output logic pixInReady,
   // Configuration pins
   input wire logic chip_sleep_n,
   input wire logic driver_sleep_n,
   input wire logic pixel_width_select,
   input wire logic clock_edge_select,
   // Panel outputs
   output logic pixel_out_clock,
   output logic [23:0] even_pixel_bus,
   output logic [23:0] odd_pixel_bus,
   output logic active_video_flag,
   output logic hsyncOut,
   output logic vsyncOut,
   output logic [1:0] user_control_out,
   output logic sync_detect_out,
   output logic busOe,
   output logic keepOe
);
   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   rpo_pins_t pinRaw, pinMeta_q, pinSync_q;
   logic linkClkOld_q;

   assign pinRaw = '{chipSleepN: chip_sleep_n, drvSleepN: driver_sleep_n,
      widthSel: pixel_width_select, edgeSel: clock_edge_select,
      syncDet: syncDetIn, pixClk: pixClkIn, pix: pixIn};

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         pinMeta_q <= PINS_RST;
         pinSync_q <= PINS_RST;
         linkClkOld_q <= 1'b0;
      end else begin
         pinMeta_q <= pinRaw;
         pinSync_q <= pinMeta_q;
         linkClkOld_q <= pinSync_q.pixClk;
      end
   end

   logic chipAwake, drvAwake, twoPix, edgeSel, linkRise;
   assign chipAwake = pinSync_q.chipSleepN;
   assign drvAwake = pinSync_q.drvSleepN;
   assign twoPix = pinSync_q.widthSel;
   assign edgeSel = pinSync_q.edgeSel;
   assign linkRise = chipAwake && pinSync_q.pixClk && !linkClkOld_q;

   // ----------------------------------------------------------------
   // Buffer
   // ----------------------------------------------------------------
   // The link cannot be paused here, so a refused word is counted as overflow.
   logic fifoRdy, fifoVld, pop;
   rpo_pix_t fifoWord;
   logic [$clog2(DEPTH):0] fifoCount;

   rpo_fifo #(.WIDTH($bits(rpo_pix_t)), .DEPTH(DEPTH)) buffer (
      .clk(clk),
      .sys_rst(sys_rst),
      .flush(!chipAwake),
      .inVld(linkRise),
      .inRdy(fifoRdy),
      .inData(pinSync_q.pix),
      .outVld(fifoVld),
      .outRdy(pop),
      .outData(fifoWord),
      .count(fifoCount)
   );
   assign pixInReady = fifoRdy;

   // ----------------------------------------------------------------
   // Register file
   // ----------------------------------------------------------------
   logic [1:0] ctrl_q, ctrl_d;
   logic ovf_q, ovf_d, ack_q, ack_d, holdVld_q;
   logic [31:0] rdat_q, rdat_d;
   logic wbReq;

   assign wbReq = wb_cyc_i && wb_stb_i && !ack_q;
   assign wb_ack_o = ack_q;
   assign wb_dat_o = rdat_q;

   always_comb begin
      ctrl_d = ctrl_q;
      ovf_d = ovf_q;
      rdat_d = '0;
      ack_d = wbReq;
      if (wbReq && wb_we_i && wb_adr_i == ADR_CTRL && wb_sel_i[0]) begin
         ctrl_d = wb_dat_i[1:0];
         ctrl_d[CTRL_CLR_OVF] = 1'b0;
         if (wb_dat_i[CTRL_CLR_OVF]) begin
            ovf_d = 1'b0;
         end
      end
      // Set wins over a clear in the same cycle.
      if (linkRise && !fifoRdy) begin
         ovf_d = 1'b1;
      end
      if (wbReq && !wb_we_i) begin
         if (wb_adr_i == ADR_CTRL) begin
            rdat_d[1:0] = ctrl_q;
         end else if (wb_adr_i == ADR_STATUS) begin
            rdat_d[ST_COUNT_LSB +: $bits(fifoCount)] = fifoCount;
            rdat_d[ST_OVF] = ovf_q;
            rdat_d[ST_CHIP_AWAKE] = chipAwake;
            rdat_d[ST_DRV_AWAKE] = drvAwake;
            rdat_d[ST_TWO_PIX] = twoPix;
            rdat_d[ST_HOLD] = holdVld_q;
         end
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         ctrl_q <= CTRL_RST;
         ovf_q <= 1'b0;
         ack_q <= 1'b0;
         rdat_q <= '0;
      end else begin
         ctrl_q <= ctrl_d;
         ovf_q <= ovf_d;
         ack_q <= ack_d;
         rdat_q <= rdat_d;
      end
   end

   // ----------------------------------------------------------------
   // Output sequencer
   // ----------------------------------------------------------------
   rpo_ostate_t st_q, st_d;
   logic [15:0] cnt_q, cnt_d;
   logic oclk_q, oclk_d, holdVld_d, launch;
   rpo_pix_t hold_q, hold_d, even_q, even_d, odd_q, odd_d;
   logic sdet_q, sdet_d, busOe_q, busOe_d, keepOe_q, keepOe_d;

   always_comb begin
      st_d = st_q;
      cnt_d = cnt_q;
      oclk_d = oclk_q;
      hold_d = hold_q;
      holdVld_d = holdVld_q;
      even_d = even_q;
      odd_d = odd_q;
      pop = 1'b0;
      launch = 1'b0;
      keepOe_d = chipAwake;
      busOe_d = chipAwake && drvAwake;
      sdet_d = chipAwake && pinSync_q.syncDet;
      unique case (st_q)
         OS_IDLE: begin
            oclk_d = !edgeSel;
            if (ctrl_q[CTRL_LAUNCH_EN]) begin
               if (holdVld_q) begin
                  if (twoPix && fifoVld && fifoWord.de) begin
                     pop = 1'b1;
                     even_d = hold_q;
                     odd_d = fifoWord;
                     launch = 1'b1;
                  end else if (!twoPix || fifoVld) begin
                     // A lone trailing even pixel leaves with the odd bus low.
                     even_d = hold_q;
                     odd_d = PIX_ZERO;
                     launch = 1'b1;
                  end
                  holdVld_d = !launch;
               end else if (fifoVld) begin
                  pop = 1'b1;
                  if (twoPix && fifoWord.de) begin
                     hold_d = fifoWord;
                     holdVld_d = 1'b1;
                  end else begin
                     even_d = fifoWord;
                     odd_d = PIX_ZERO;
                     launch = 1'b1;
                  end
               end
            end
            if (launch) begin
               st_d = OS_LAUNCH;
               cnt_d = 16'(HALF_CYC - 1);
            end
         end
         OS_LAUNCH: begin
            if (cnt_q == '0) begin
               oclk_d = edgeSel;
               st_d = OS_CAPTURE;
               cnt_d = 16'(HALF_CYC - 1);
            end else begin
               cnt_d = cnt_q - 1'b1;
            end
         end
         OS_CAPTURE: begin
            if (cnt_q == '0) begin
               oclk_d = !edgeSel;
               st_d = OS_IDLE;
            end else begin
               cnt_d = cnt_q - 1'b1;
            end
         end
         default: begin
            st_d = OS_IDLE;
         end
      endcase
      if (!chipAwake) begin
         st_d = OS_IDLE;
         holdVld_d = 1'b0;
         even_d = PIX_ZERO;
         odd_d = PIX_ZERO;
         oclk_d = !edgeSel;
         pop = 1'b0;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         st_q <= OS_IDLE;
         cnt_q <= '0;
         oclk_q <= 1'b1;
         hold_q <= PIX_ZERO;
         holdVld_q <= 1'b0;
         even_q <= PIX_ZERO;
         odd_q <= PIX_ZERO;
         sdet_q <= 1'b0;
         busOe_q <= 1'b0;
         keepOe_q <= 1'b0;
      end else begin
         st_q <= st_d;
         cnt_q <= cnt_d;
         oclk_q <= oclk_d;
         hold_q <= hold_d;
         holdVld_q <= holdVld_d;
         even_q <= even_d;
         odd_q <= odd_d;
         sdet_q <= sdet_d;
         busOe_q <= busOe_d;
         keepOe_q <= keepOe_d;
      end
   end

   // ----------------------------------------------------------------
   // Pin mapping
   // ----------------------------------------------------------------
   // launched with clock
   assign pixel_out_clock = oclk_q;
   assign even_pixel_bus[7:0] = even_q.blue;
   assign even_pixel_bus[15:8] = even_q.green;
   assign even_pixel_bus[23:16] = even_q.red;
   assign odd_pixel_bus = {odd_q.red, odd_q.green, odd_q.blue};
   assign active_video_flag = even_q.de;
   assign hsyncOut = even_q.hsync;
   assign vsyncOut = even_q.vsync;
   assign user_control_out = even_q.ctl;
   assign sync_detect_out = sdet_q;
   assign busOe = busOe_q;
   assign keepOe = keepOe_q;
endmodule : rpo_pixel_out

`default_nettype wire

// ### rpo_pixel_out_checker.sv
`timescale 1ns/1ps
`default_nettype none

module rpo_pixel_out_checker #(
   parameter int HALF_CYC = 2
) (
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Bus
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   input wire logic [31:0] wb_dat_o,
   // Pins
   input wire logic chip_sleep_n,
   input wire logic driver_sleep_n,
   input wire logic pixel_width_select,
   input wire logic clock_edge_select,
   input wire logic pixInReady,
   // Panel side
   input wire logic pixel_out_clock,
   input wire logic [23:0] even_pixel_bus,
   input wire logic [23:0] odd_pixel_bus,
   input wire logic active_video_flag,
   input wire logic hsyncOut,
   input wire logic vsyncOut,
   input wire logic [1:0] user_control_out,
   input wire logic sync_detect_out,
   input wire logic busOe,
   input wire logic keepOe
);
   // Capture edge comes one output half period after launch, two at the most.
   localparam int CAPT_MIN = 1;
   localparam int CAPT_MAX = 2 * HALF_CYC;
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   // Pins pass two sync stages and a register, so three samples.
   sequence asleep_s; !chip_sleep_n [*3]; endsequence
   sequence drvoff_s; (chip_sleep_n && !driver_sleep_n) [*3]; endsequence
   sequence awake_s; (chip_sleep_n && driver_sleep_n) [*3]; endsequence
   sequence onepix_s; !pixel_width_select [*4] ##0 $changed(even_pixel_bus); endsequence
   sequence capt_s; busOe && $changed(pixel_out_clock) && pixel_out_clock == clock_edge_select;
   endsequence
   chip_off_a: assert property (asleep_s |=> !busOe && !keepOe) else $error("oe on asleep");
   chip_quiet_a: assert property (asleep_s |=> !pixInReady && !sync_detect_out &&
      even_pixel_bus == '0) else $error("active while asleep");
   drv_off_a: assert property (drvoff_s |=> !busOe && keepOe) else $error("driver sleep oe");
   wake_on_a: assert property (awake_s |=> busOe && keepOe) else $error("oe off awake");
   odd_low_a: assert property (onepix_s |-> odd_pixel_bus == '0) else $error("odd bus set");
   capt_hold_a: assert property (capt_s |-> ($stable(even_pixel_bus) &&
      $stable(odd_pixel_bus) && $stable(active_video_flag)) [*2]) else $error("data moved");
   ctl_sync_a: assert property (busOe && $past(busOe) && (!$stable(hsyncOut) ||
      !$stable(vsyncOut) || !$stable(user_control_out) || !$stable(active_video_flag))
      |-> pixel_out_clock != clock_edge_select) else $error("control off clock");
   capt_soon_a: assert property (busOe && $past(busOe) && $changed(even_pixel_bus) |->
      ##[CAPT_MIN:CAPT_MAX] (pixel_out_clock == clock_edge_select)) else $error("no capture");
   bus_ack_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("no ack");
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o && wb_dat_o == '0)
      else $error("ack too long");
endmodule : rpo_pixel_out_checker

bind rpo_pixel_out rpo_pixel_out_checker #(.HALF_CYC(HALF_CYC)) chkr (.clk, .sys_rst,
   .wb_cyc_i, .wb_stb_i, .wb_ack_o, .wb_dat_o, .chip_sleep_n, .driver_sleep_n,
   .pixel_width_select, .clock_edge_select, .pixInReady, .pixel_out_clock, .even_pixel_bus,
   .odd_pixel_bus, .active_video_flag, .hsyncOut, .vsyncOut, .user_control_out,
   .sync_detect_out, .busOe, .keepOe);

`default_nettype wire

// ### rpo_panel_model.sv
`timescale 1ns/1ps
`default_nettype none

module rpo_panel_model (
   // Panel inputs
   input wire logic pixel_out_clock,
   input wire logic clock_edge_select,
   input wire logic busOe,
   input wire logic [23:0] even_pixel_bus,
   input wire logic [23:0] odd_pixel_bus,
   input wire logic active_video_flag,
   input wire logic hsyncOut,
   input wire logic vsyncOut,
   input wire logic [1:0] user_control_out,
   // Capture record
   output int capCount
);
   logic [52:0] cap [64];
   initial capCount = 0;
   task automatic take();
      cap[capCount[5:0]] = {user_control_out, vsyncOut, hsyncOut, active_video_flag,
         odd_pixel_bus, even_pixel_bus};
      capCount++;
   endtask : take
   always @(posedge pixel_out_clock)
      if (clock_edge_select && busOe) take();
   // falling edge when select is low.
   always @(negedge pixel_out_clock)
      if (!clock_edge_select && busOe) take();
endmodule : rpo_panel_model

`default_nettype wire

// ### tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top
   import rpo_pkg::*;
;
   // ------
   // Wiring
   // ------
   logic clk = 0, sys_rst = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, wb_ack_o;
   logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'h0, selUse = 4'hF;
   logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o, rd;
   logic pixClkIn = 0, syncDetIn = 0, pixInReady, chip_sleep_n = 1, driver_sleep_n = 1;
   logic pixel_width_select = 0, clock_edge_select = 1, pixel_out_clock, active_video_flag;
   logic hsyncOut, vsyncOut, sync_detect_out, busOe, keepOe;
   logic [23:0] even_pixel_bus, odd_pixel_bus;
   logic [1:0] user_control_out;
   rpo_pix_t pixIn = PIX_ZERO;
   int failures = 0, cmp_count = 0, capCount, base;
   localparam rpo_pix_t WA = 29'h0112_3456, WB = 29'h01AB_CDEF, WC = 29'h0165_4321;
   localparam rpo_pix_t WD = 29'h0102_0408, WE = 29'h0180_4020, WK = 29'h1E00_0000;

   always #12.5 clk = ~clk;

   rpo_pixel_out dut (.clk, .sys_rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
      .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .pixClkIn, .pixIn, .syncDetIn,
      .pixInReady, .chip_sleep_n, .driver_sleep_n, .pixel_width_select, .clock_edge_select,
      .pixel_out_clock, .even_pixel_bus, .odd_pixel_bus, .active_video_flag, .hsyncOut,
      .vsyncOut, .user_control_out, .sync_detect_out, .busOe, .keepOe);
   rpo_panel_model panel (.pixel_out_clock, .clock_edge_select, .busOe, .even_pixel_bus,
      .odd_pixel_bus, .active_video_flag, .hsyncOut, .vsyncOut, .user_control_out,
      .capCount);

   // ------
   // Helpers
   // ------
   task automatic give_verdict();
      $display("compares %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : give_verdict
   task automatic chk(input string n, input logic [52:0] e, input logic [52:0] g);
      cmp_count++;
      if (g !== e) begin
         failures++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic cycles(input int n);
      repeat (n) @(posedge clk);
   endtask : cycles
   // Sync and user control travel with the even word of each launch.
   function automatic logic [52:0] ex(input logic d, input rpo_pix_t o, input rpo_pix_t e);
      return {e.ctl, e.vsync, e.hsync, d, o.red, o.green, o.blue, e.red, e.green, e.blue};
   endfunction : ex
   task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      wb_cyc_i <= 1;
      wb_stb_i <= 1;
      wb_we_i <= we;
      wb_sel_i <= selUse;
      wb_adr_i <= a;
      wb_dat_i <= d;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      rd = wb_dat_o;
      wb_cyc_i <= 0;
      wb_stb_i <= 0;
      wb_sel_i <= 4'h0;
      if (n >= 20) begin
         failures++;
         give_verdict();
      end
   endtask : wb
   // The link clock stands still between words; data flips when idle.
   task automatic send(input rpo_pix_t p);
      @(posedge clk);
      pixIn <= p;
      cycles(3);
      pixClkIn <= 1;
      cycles(4);
      pixClkIn <= 0;
      pixIn <= ~p;
   endtask : send
   task automatic waitcap(input int n);
      for (int k = 0; k < 600 && capCount < n; k++) @(posedge clk);
      if (capCount < n) begin
         failures++;
         give_verdict();
      end
   endtask : waitcap

   // ------
   // Scenarios
   // ------
   task automatic t_reg();
      wb(0, ADR_CTRL, 0);
      chk("ctrl reset", 32'h0000_0001, rd);
      wb(1, 4'h8, 32'hFFFF_FFFF);
      wb(0, 4'h8, 0);
      chk("unmapped", 0, rd);
      selUse = 4'hE;
      wb(1, ADR_CTRL, 32'h0000_0000);
      selUse = 4'hF;
      wb(0, ADR_CTRL, 0);
      chk("sel guard", 32'h0000_0001, rd);
   endtask : t_reg
   task automatic t_one();
      base = capCount;
      send(WA);
      send(WB);
      waitcap(base + 2);
      chk("one first", ex(1, PIX_ZERO, WA), panel.cap[base]);
      chk("one second", ex(1, PIX_ZERO, WB), panel.cap[base + 1]);
   endtask : t_one
   task automatic t_two();
      logic [52:0] exp [5];
      rpo_pix_t seq [7];
      seq = '{WK, WA, WB, WC, WK, WD, WE};
      exp = '{ex(0, PIX_ZERO, WK), ex(1, WB, WA), ex(1, PIX_ZERO, WC), ex(0, PIX_ZERO, WK),
         ex(1, WE, WD)};
      pixel_width_select <= 1;
      cycles(4);
      base = capCount;
      foreach (seq[i]) send(seq[i]);
      waitcap(base + 5);
      foreach (exp[i]) chk("two pixel", exp[i], panel.cap[base + i]);
      pixel_width_select <= 0;
   endtask : t_two
   task automatic t_edge();
      // Let the last output clock settle so no edge is seen under the new select.
      cycles(2);
      clock_edge_select <= 0;
      cycles(4);
      base = capCount;
      send(WC);
      waitcap(base + 1);
      chk("falling capture", ex(1, PIX_ZERO, WC), panel.cap[base]);
      cycles(2);
      clock_edge_select <= 1;
      cycles(4);
   endtask : t_edge
   task automatic t_sleep();
      syncDetIn <= 1;
      driver_sleep_n <= 0;
      cycles(4);
      chk("driver sleep", 3'b011, {busOe, keepOe, sync_detect_out});
      driver_sleep_n <= 1;
      chip_sleep_n <= 0;
      cycles(4);
      chk("chip sleep", 0, {busOe, keepOe, sync_detect_out, pixInReady});
      base = capCount;
      send(WA);
      chip_sleep_n <= 1;
      cycles(4);
      chk("wake", 3'b111, {busOe, keepOe, sync_detect_out});
      send(WB);
      waitcap(base + 1);
      chk("wake pixel", ex(1, PIX_ZERO, WB), panel.cap[base]);
   endtask : t_sleep
   task automatic t_fifo();
      wb(1, ADR_CTRL, 32'h0000_0000);
      base = capCount;
      repeat (33) send(WD);
      cycles(4);
      chk("full ready", 0, pixInReady);
      wb(0, ADR_STATUS, 0);
      chk("full status", 32'h0000_0720, rd);
      wb(1, ADR_CTRL, 32'h0000_0003);
      waitcap(base + 32);
      wb(0, ADR_STATUS, 0);
      chk("drained status", 32'h0000_0600, rd);
   endtask : t_fifo

   initial begin
      cycles(6);
      sys_rst <= 0;
      t_reg();
      t_one();
      t_two();
      t_edge();
      t_sleep();
      t_fifo();
      give_verdict();
   end
endmodule : tb_top

`default_nettype wire
